// File: hdl/cltd_defs.svh
// instruction patterns, flag positions and cycle counts for the decoder
`ifndef CLTD_DEFS_SVH
`define CLTD_DEFS_SVH

// ------------------------------------------------------------
// whole-word inherent opcodes
// ------------------------------------------------------------
`define CLTD_W_NO_OPERATION  16'h0000
`define CLTD_W_STANDBY       16'h0003
`define CLTD_W_WATCHDOG_CLR  16'h0004
`define CLTD_W_STACK_PUSH    16'h0005
`define CLTD_W_STACK_POP     16'h0006
`define CLTD_W_DECIMAL_ADJ   16'h0007
`define CLTD_W_SOFT_RESET    16'h00ff

// ------------------------------------------------------------
// wildcard patterns, matched with casez
// ------------------------------------------------------------
`define CLTD_P_INT_RETURN    16'b0000_0000_0001_000?
`define CLTD_P_SUB_RETURN    16'b0000_0000_0001_001?
`define CLTD_P_TABLE_READ    16'b0000_0000_0000_10??
`define CLTD_P_TABLE_WRITE   16'b0000_0000_0000_11??
`define CLTD_P_BANK_LOAD     16'b0000_0001_0000_????
`define CLTD_P_LIT_SUBTRACT  16'b0000_1000_????_????
`define CLTD_P_LIT_OR        16'b0000_1001_????_????
`define CLTD_P_LIT_XOR       16'b0000_1010_????_????
`define CLTD_P_LIT_AND       16'b0000_1011_????_????
`define CLTD_P_EXIT_LITERAL  16'b0000_1100_????_????
`define CLTD_P_LIT_MULTIPLY  16'b0000_1101_????_????
`define CLTD_P_LIT_LOAD      16'b0000_1110_????_????
`define CLTD_P_LIT_ADD       16'b0000_1111_????_????
`define CLTD_P_JUMP_REL      16'b1101_0???_????_????
`define CLTD_P_INVOKE_REL    16'b1101_1???_????_????
`define CLTD_P_PTR_LOAD      16'b1110_1110_00??_????
`define CLTD_P_ABS_JUMP      16'b1110_1111_????_????
`define CLTD_P_SUB_CALL      16'b1110_110?_????_????
`define CLTD_P_BRANCH_COND   16'b1110_0???_????_????
`define CLTD_P_SECOND_WORD   16'b1111_????_????_????

// ------------------------------------------------------------
// branch condition codes
// ------------------------------------------------------------
`define CLTD_CC_ZERO         3'h0
`define CLTD_CC_NONZERO      3'h1
`define CLTD_CC_CARRY        3'h2
`define CLTD_CC_NO_CARRY     3'h3
`define CLTD_CC_WRAP         3'h4
`define CLTD_CC_NO_WRAP      3'h5
`define CLTD_CC_NEGATIVE     3'h6
`define CLTD_CC_NOT_NEG      3'h7

// ------------------------------------------------------------
// status update mask bit positions and values
// ------------------------------------------------------------
`define CLTD_FLAG_CARRY      0
`define CLTD_FLAG_DIGIT      1
`define CLTD_FLAG_ZERO       2
`define CLTD_FLAG_WRAP       3
`define CLTD_FLAG_NEGATIVE   4
`define CLTD_FLAG_TIME_PWR   5
`define CLTD_FLAG_INT_EN     6
`define CLTD_MASK_NONE       7'h00
`define CLTD_MASK_ALL        7'h7f
`define CLTD_MASK_ARITH      7'h1f
`define CLTD_MASK_LOGIC      7'h14

// ------------------------------------------------------------
// cycle counts and program counter step
// ------------------------------------------------------------
`define CLTD_CYC_ONE         3'h1
`define CLTD_CYC_TWO         3'h2
`define CLTD_CYC_TBL_LONG    3'h5
`define CLTD_PC_STEP         21'h000002

`endif

// File: hdl/cltd_pkg.sv
// types shared by the control, literal and table decoder
package cltd_pkg;

  typedef enum logic [4:0] {
    OP_NO_OPERATION, OP_STANDBY, OP_WATCHDOG_CLEAR, OP_STACK_PUSH, OP_STACK_POP,
    OP_DECIMAL_ADJUST, OP_SOFT_RESET, OP_INTERRUPT_RETURN, OP_SUB_RETURN,
    OP_TABLE_READ, OP_TABLE_WRITE, OP_BANK_LITERAL_LOAD, OP_LITERAL_SUBTRACT,
    OP_LITERAL_OR, OP_LITERAL_XOR, OP_LITERAL_AND, OP_EXIT_WITH_LITERAL,
    OP_LITERAL_MULTIPLY, OP_LITERAL_LOAD, OP_LITERAL_ADD, OP_BRANCH_COND,
    OP_JUMP_RELATIVE, OP_RELATIVE_INVOKE, OP_SUB_CALL, OP_ABSOLUTE_JUMP,
    OP_POINTER_LITERAL_LOAD, OP_OUTSIDE_GROUP
  } cltd_op_t;

  typedef enum logic [1:0] {
    PH_FIRST, PH_SECOND, PH_FILL
  } cltd_phase_t;

  typedef struct packed {
    cltd_phase_t phase;
    logic [2:0]  fillCnt;
    cltd_op_t    pendOp;
    logic [7:0]  pendLow;
    logic        opValid;
    cltd_op_t    op;
    logic [7:0]  lit8;
    logic [11:0] lit12;
    logic [1:0]  fsrSel;
    logic [1:0]  tblMode;
    logic        shadowSel;
    logic [6:0]  flagMask;
    logic [2:0]  cycles;
    logic        pcLoad;
    logic [20:0] pcTarget;
    logic        tblBusy;
    logic        prescClear;
    logic        rmwFromPins;
  } cltd_state_t;

endpackage

// File: hdl/cltd_dec_if.sv
// signals between the decoder core and its branch and flag helpers
`timescale 1ns/1ps
`default_nettype none

interface cltd_dec_if;
  import cltd_pkg::*;
  logic [2:0]  condCode;
  logic [3:0]  flags;
  logic [10:0] offset;
  logic [20:0] pcCur;
  logic        condTaken;
  logic [20:0] relTarget;
  cltd_op_t    op;
  logic [6:0]  flagMask;
  logic [2:0]  baseCycles;

  modport core   (output condCode, flags, offset, pcCur, op,
                  input condTaken, relTarget, flagMask, baseCycles);
  modport branch (input condCode, flags, offset, pcCur, output condTaken, relTarget);
  modport flagmap(input op, output flagMask, baseCycles);
endinterface

`default_nettype wire

// File: hdl/cltd_branch_unit.sv
// branch condition test and relative target adder
`timescale 1ns/1ps
`default_nettype none
`include "cltd_defs.svh"

module cltd_branch_unit
  import cltd_pkg::*;
(
  cltd_dec_if.branch bu
);
  // flags order: {negative, wrap, carry, zero}
  always_comb
  begin
    unique case (bu.condCode)
      `CLTD_CC_ZERO:     bu.condTaken = bu.flags[0];
      `CLTD_CC_NONZERO:  bu.condTaken = !bu.flags[0];
      `CLTD_CC_CARRY:    bu.condTaken = bu.flags[1];
      `CLTD_CC_NO_CARRY: bu.condTaken = !bu.flags[1];
      `CLTD_CC_WRAP:     bu.condTaken = bu.flags[2];
      `CLTD_CC_NO_WRAP:  bu.condTaken = !bu.flags[2];
      `CLTD_CC_NEGATIVE: bu.condTaken = bu.flags[3];
      `CLTD_CC_NOT_NEG:  bu.condTaken = !bu.flags[3];
    endcase
  end

  // offset counts words, so it is doubled before the add
  assign bu.relTarget = bu.pcCur + `CLTD_PC_STEP
                        + {{9{bu.offset[10]}}, bu.offset, 1'b0};
endmodule

`default_nettype wire

// File: hdl/cltd_flag_map.sv
// status update mask and base cycle count per decoded operation
`timescale 1ns/1ps
`default_nettype none
`include "cltd_defs.svh"

module cltd_flag_map
  import cltd_pkg::*;
(
  cltd_dec_if.flagmap fm
);
  always_comb
  begin
    fm.flagMask   = `CLTD_MASK_NONE;
    fm.baseCycles = `CLTD_CYC_ONE;
    unique case (fm.op)
      OP_STANDBY, OP_WATCHDOG_CLEAR:
        fm.flagMask = 7'h01 << `CLTD_FLAG_TIME_PWR;
      OP_DECIMAL_ADJUST:
        fm.flagMask = 7'h01 << `CLTD_FLAG_CARRY;
      OP_SOFT_RESET:
        fm.flagMask = `CLTD_MASK_ALL;
      OP_INTERRUPT_RETURN:
      begin
        fm.flagMask   = 7'h01 << `CLTD_FLAG_INT_EN;
        fm.baseCycles = `CLTD_CYC_TWO;
      end
      OP_LITERAL_ADD, OP_LITERAL_SUBTRACT:
        fm.flagMask = `CLTD_MASK_ARITH;
      OP_LITERAL_AND, OP_LITERAL_OR, OP_LITERAL_XOR:
        fm.flagMask = `CLTD_MASK_LOGIC;
      OP_SUB_RETURN, OP_EXIT_WITH_LITERAL, OP_TABLE_READ, OP_TABLE_WRITE,
      OP_JUMP_RELATIVE, OP_RELATIVE_INVOKE, OP_SUB_CALL, OP_ABSOLUTE_JUMP,
      OP_POINTER_LITERAL_LOAD:
        fm.baseCycles = `CLTD_CYC_TWO;
      default:
        fm.baseCycles = `CLTD_CYC_ONE;
    endcase
  end
endmodule

`default_nettype wire

// File: hdl/cltd_decoder.sv
// control, literal and table instruction decoder of the 8-bit core
//
`timescale 1ns/1ps
`default_nettype none
`include "cltd_defs.svh"

module cltd_decoder
  import cltd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  input  wire logic [20:0] instrAddr,
  input  wire logic        flagZero,
  input  wire logic        flagCarry,
  input  wire logic        flagWrap,
  input  wire logic        flagNegative,
  input  wire logic        tblWriteStartsMem,
  input  wire logic        memWriteDone,
  input  wire logic        timerZeroWrite,
  input  wire logic        prescalerOnTimerZero,
  input  wire logic        portRmwAccess,
  output logic             instrReady,
  output logic             opValid,
  output cltd_op_t         opCode,
  output logic [7:0]       literal8,
  output logic [11:0]      literal12,
  output logic [1:0]       pointerSel,
  output logic [1:0]       tableMode,
  output logic             shadowSel,
  output logic [6:0]       statusUpdateMask,
  output logic [2:0]       opCycles,
  output logic             pcLoad,
  output logic [20:0]      pcTarget,
  output logic             tblWriteActive,
  output logic             prescalerClear,
  output logic             rmwFromPins
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  cltd_dec_if ifc ();

  cltd_branch_unit u_branch (
    .bu (ifc.branch)
  );

  cltd_flag_map u_flags (
    .fm (ifc.flagmap)
  );

  cltd_state_t cur_reg;
  cltd_state_t cur_next;
  cltd_op_t    wordOp;

  // ------------------------------------------------------------
  // first-word classification
  // ------------------------------------------------------------
  // more specific 1110 patterns come before the branch pattern
  always_comb
  begin
    casez (instrWord)
      `CLTD_W_NO_OPERATION: wordOp = OP_NO_OPERATION;
      `CLTD_W_STANDBY:      wordOp = OP_STANDBY;
      `CLTD_W_WATCHDOG_CLR: wordOp = OP_WATCHDOG_CLEAR;
      `CLTD_W_STACK_PUSH:   wordOp = OP_STACK_PUSH;
      `CLTD_W_STACK_POP:    wordOp = OP_STACK_POP;
      `CLTD_W_DECIMAL_ADJ:  wordOp = OP_DECIMAL_ADJUST;
      `CLTD_W_SOFT_RESET:   wordOp = OP_SOFT_RESET;
      `CLTD_P_INT_RETURN:   wordOp = OP_INTERRUPT_RETURN;
      `CLTD_P_SUB_RETURN:   wordOp = OP_SUB_RETURN;
      `CLTD_P_TABLE_READ:   wordOp = OP_TABLE_READ;
      `CLTD_P_TABLE_WRITE:  wordOp = OP_TABLE_WRITE;
      `CLTD_P_BANK_LOAD:    wordOp = OP_BANK_LITERAL_LOAD;
      `CLTD_P_LIT_SUBTRACT: wordOp = OP_LITERAL_SUBTRACT;
      `CLTD_P_LIT_OR:       wordOp = OP_LITERAL_OR;
      `CLTD_P_LIT_XOR:      wordOp = OP_LITERAL_XOR;
      `CLTD_P_LIT_AND:      wordOp = OP_LITERAL_AND;
      `CLTD_P_EXIT_LITERAL: wordOp = OP_EXIT_WITH_LITERAL;
      `CLTD_P_LIT_MULTIPLY: wordOp = OP_LITERAL_MULTIPLY;
      `CLTD_P_LIT_LOAD:     wordOp = OP_LITERAL_LOAD;
      `CLTD_P_LIT_ADD:      wordOp = OP_LITERAL_ADD;
      `CLTD_P_JUMP_REL:     wordOp = OP_JUMP_RELATIVE;
      `CLTD_P_INVOKE_REL:   wordOp = OP_RELATIVE_INVOKE;
      `CLTD_P_PTR_LOAD:     wordOp = OP_POINTER_LITERAL_LOAD;
      `CLTD_P_ABS_JUMP:     wordOp = OP_ABSOLUTE_JUMP;
      `CLTD_P_SUB_CALL:     wordOp = OP_SUB_CALL;
      `CLTD_P_BRANCH_COND:  wordOp = OP_BRANCH_COND;
      `CLTD_P_SECOND_WORD:  wordOp = OP_NO_OPERATION;
      default:              wordOp = OP_OUTSIDE_GROUP;
    endcase
  end

  // ------------------------------------------------------------
  // helper inputs
  // ------------------------------------------------------------
  always_comb
  begin
    ifc.condCode = instrWord[10:8];
    ifc.flags    = {flagNegative, flagWrap, flagCarry, flagZero};
    ifc.pcCur    = instrAddr;
    if (wordOp == OP_BRANCH_COND)
      ifc.offset = {{3{instrWord[7]}}, instrWord[7:0]};
    else
      ifc.offset = instrWord[10:0];
    ifc.op = (cur_reg.phase == PH_SECOND) ? cur_reg.pendOp : wordOp;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [2:0] cyc;
    cyc = ifc.baseCycles;
    cur_next = cur_reg;
    cur_next.opValid     = 1'b0;
    cur_next.pcLoad      = 1'b0;
    cur_next.prescClear  = timerZeroWrite && prescalerOnTimerZero;
    cur_next.rmwFromPins = portRmwAccess;
    // the memory write runs on past the stall until memory reports its end
    if (cur_reg.tblBusy && memWriteDone)
      cur_next.tblBusy = 1'b0;

    unique case (cur_reg.phase)
      PH_FILL:
      begin
        // empty cycles in which nothing is executed
        cur_next.fillCnt = cur_reg.fillCnt - 3'h1;
        if (cur_reg.fillCnt == 3'h1)
          cur_next.phase = PH_FIRST;
      end

      PH_SECOND:
      begin
        if (instrValid)
        begin
          // second word supplies the rest of the operand
          cur_next.opValid  = 1'b1;
          cur_next.op       = cur_reg.pendOp;
          cur_next.flagMask = ifc.flagMask;
          cur_next.cycles   = ifc.baseCycles;
          cur_next.phase    = PH_FIRST;
          if (cur_reg.pendOp == OP_POINTER_LITERAL_LOAD)
            cur_next.lit12 = {cur_reg.pendLow[3:0], instrWord[7:0]};
          else
          begin
            cur_next.pcLoad   = 1'b1;
            cur_next.pcTarget = {instrWord[11:0], cur_reg.pendLow, 1'b0};
          end
        end
      end

      PH_FIRST:
      begin
        if (instrValid)
        begin
          cur_next.op       = wordOp;
          cur_next.flagMask = ifc.flagMask;
          cur_next.lit8     = instrWord[7:0];
          cur_next.tblMode  = instrWord[1:0];
          cur_next.shadowSel = instrWord[0];
          unique case (wordOp)
            OP_POINTER_LITERAL_LOAD, OP_SUB_CALL, OP_ABSOLUTE_JUMP:
            begin
              // hold the first word and wait for its operand word
              cur_next.pendOp  = wordOp;
              cur_next.pendLow = instrWord[7:0];
              cur_next.phase   = PH_SECOND;
              if (wordOp == OP_POINTER_LITERAL_LOAD)
                cur_next.fsrSel = instrWord[5:4];
              if (wordOp == OP_SUB_CALL)
                cur_next.shadowSel = instrWord[8];
            end
            default:
            begin
              cur_next.opValid = 1'b1;
              if (wordOp == OP_BANK_LITERAL_LOAD)
                cur_next.lit8 = {4'h0, instrWord[3:0]};
              if (wordOp == OP_BRANCH_COND)
                cyc = ifc.condTaken ? `CLTD_CYC_TWO : `CLTD_CYC_ONE;
              if (wordOp == OP_TABLE_WRITE && tblWriteStartsMem)
              begin
                cyc = `CLTD_CYC_TBL_LONG;
                cur_next.tblBusy = 1'b1;
              end
              if (wordOp == OP_JUMP_RELATIVE || wordOp == OP_RELATIVE_INVOKE
                  || (wordOp == OP_BRANCH_COND && ifc.condTaken))
              begin
                cur_next.pcLoad   = 1'b1;
                cur_next.pcTarget = ifc.relTarget;
              end
              if (wordOp == OP_INTERRUPT_RETURN || wordOp == OP_SUB_RETURN
                  || wordOp == OP_EXIT_WITH_LITERAL)
                cur_next.pcLoad = 1'b1;
              cur_next.cycles = cyc;
              if (cyc != `CLTD_CYC_ONE)
              begin
                cur_next.phase   = PH_FILL;
                cur_next.fillCnt = cyc - 3'h1;
              end
            end
          endcase
        end
      end

      default:
        cur_next.phase = PH_FIRST;
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur_reg <= '0;
      cur_reg.phase  <= PH_FIRST;
      cur_reg.op     <= OP_NO_OPERATION;
      cur_reg.pendOp <= OP_NO_OPERATION;
    end
    else
      cur_reg <= cur_next;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // during the empty cycles the fetch unit must hold off
  assign instrReady       = (cur_reg.phase != PH_FILL);
  assign opValid          = cur_reg.opValid;
  assign opCode           = cur_reg.op;
  assign literal8         = cur_reg.lit8;
  assign literal12        = cur_reg.lit12;
  assign pointerSel       = cur_reg.fsrSel;
  assign tableMode        = cur_reg.tblMode;
  assign shadowSel        = cur_reg.shadowSel;
  assign statusUpdateMask = cur_reg.flagMask;
  assign opCycles         = cur_reg.cycles;
  assign pcLoad           = cur_reg.pcLoad;
  assign pcTarget         = cur_reg.pcTarget;
  assign tblWriteActive   = cur_reg.tblBusy;
  assign prescalerClear   = cur_reg.prescClear;
  assign rmwFromPins      = cur_reg.rmwFromPins;

endmodule

`default_nettype wire

// File: verification/cltd_decoder_asserts.sv
// concurrent checks on the decoder top-level ports
`timescale 1ns/1ps
`default_nettype none
module cltd_decoder_asserts
  import cltd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [20:0] instrAddr,
  input wire logic        flagZero,
  input wire logic        tblWriteStartsMem,
  input wire logic        timerZeroWrite,
  input wire logic        prescalerOnTimerZero,
  input wire logic        portRmwAccess,
  input wire logic        instrReady,
  input wire logic        opValid,
  input var  cltd_op_t    opCode,
  input wire logic [7:0]  literal8,
  input wire logic [6:0]  statusUpdateMask,
  input wire logic [2:0]  opCycles,
  input wire logic        pcLoad,
  input wire logic [20:0] pcTarget,
  input wire logic        tblWriteActive,
  input wire logic        prescalerClear,
  input wire logic        rmwFromPins
);
  logic        take;
  logic        pendReg;
  logic [20:0] brTgt;
  assign take = instrValid && instrReady;
  assign brTgt = instrAddr + 21'h2 + {{12{instrWord[7]}}, instrWord[7:0], 1'b0};
  // an operand word is not a lone 1111 word
  always_ff @(posedge clk)
  begin
    if (rst)
      pendReg <= 1'b0;
    else if (take)
      pendReg <= !pendReg && (instrWord[15:9] == 7'h76 || instrWord[15:8] == 8'hef
                 || instrWord[15:6] == 10'h3b8);
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  presc_clear_a: assert property (
    ##1 prescalerClear == ($past(timerZeroWrite) && $past(prescalerOnTimerZero)))
    else $error("prescaler clear wrong");
  pin_source_a: assert property (##1 rmwFromPins == $past(portRmwAccess))
    else $error("pin source select wrong");
  bank_load_a: assert property (
    take && instrWord[15:4] == 12'h010 |=> opValid && opCode == OP_BANK_LITERAL_LOAD
      && literal8 == {4'h0, $past(instrWord[3:0])} && statusUpdateMask == 7'h00)
    else $error("bank load wrong");
  long_table_a: assert property (
    take && instrWord[15:2] == 14'h0003 && tblWriteStartsMem |=> opCycles == 3'h5
      && tblWriteActive && !instrReady ##1 !instrReady [*3] ##1 instrReady)
    else $error("long table write timing wrong");
  branch_taken_a: assert property (
    take && instrWord[15:8] == 8'he0 && flagZero |=> pcLoad && opCycles == 3'h2
      && pcTarget == $past(brTgt))
    else $error("taken branch wrong");
  rel_jump_a: assert property (
    take && instrWord[15:12] == 4'hd |=> pcLoad && opCycles == 3'h2 && !instrReady
      ##1 instrReady)
    else $error("relative jump timing wrong");
  lone_nop_a: assert property (
    take && !pendReg && instrWord[15:12] == 4'hf |=> opValid && opCode == OP_NO_OPERATION)
    else $error("lone second word wrong");
  soft_reset_a: assert property (
    take && instrWord == 16'h00ff |=> statusUpdateMask == 7'h7f && opCycles == 3'h1)
    else $error("software reset wrong");
  cover property (take && instrWord[15:2] == 14'h0003 && tblWriteStartsMem);
  cover property (take && pendReg);
  cover property (pcLoad && opCode == OP_BRANCH_COND);
endmodule
bind cltd_decoder cltd_decoder_asserts cltd_decoder_asserts_inst (.*);
`default_nettype wire

// File: verification/cltd_prog_mem.sv
// program memory model that streams instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module cltd_prog_mem
#(
  parameter logic [20:0] BASE = 21'h000100
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        stall,
  input  wire logic        instrReady,
  output logic             instrValid,
  output logic [15:0]      instrWord,
  output logic [20:0]      instrAddr
);
  logic [15:0] mem [0:1023];
  int          n = 0;
  int          idx = 0;
  logic        vReg = 1'b0;
  assign instrValid = vReg;
  // idle bus shows ~word, so a stale word never looks fresh
  assign instrWord = vReg ? mem[idx] : ~mem[idx];
  assign instrAddr = BASE + 21'(2 * idx);
  // a word is held until taken; a stall only delays the next
  always @(posedge clk)
  begin
    if (rst)
    begin
      idx <= 0;
      vReg <= 1'b0;
    end
    else if (vReg && instrReady)
    begin
      idx <= idx + 1;
      vReg <= idx + 1 < n && !stall;
    end
    else if (!vReg)
      vReg <= go && idx < n && !stall;
  end
endmodule
`default_nettype wire

// File: verification/control_literal_table_decoder_bench.sv
// bench: random program stream through the decoder against a reference decode
`timescale 1ns/1ps
`default_nettype none
module control_literal_table_decoder_bench
  import cltd_pkg::*;
();
  typedef struct packed {
    logic [4:0]  op;
    logic [6:0]  mask;
    logic [2:0]  cyc;
    logic        pl;
    logic        ct;
    logic [20:0] tgt;
    logic [13:0] lit;
    logic [1:0]  lk;
  } cltd_exp_t;
  logic        clk = 1'b0;
  logic        rst, go, stall, instrValid, instrReady, opValid, pcLoad;
  logic        flagZero, flagCarry, flagWrap, flagNegative, tblWriteStartsMem, memWriteDone;
  logic        timerZeroWrite, prescalerOnTimerZero, portRmwAccess, tblWriteActive;
  logic        prescalerClear, rmwFromPins, pend, act, pP, pR, shadowSel;
  logic [1:0]  tableMode, pointerSel;
  logic [15:0] instrWord, pw;
  logic [20:0] instrAddr, pcTarget;
  logic [11:0] literal12;
  logic [7:0]  literal8;
  logic [6:0]  statusUpdateMask;
  logic [2:0]  opCycles;
  cltd_op_t    opCode;
  cltd_exp_t   q[$];
  cltd_exp_t   e, s;
  int          mismatches = 0;
  int          nChecks = 0;
  logic [31:0] tpl [0:26] = '{32'h0, 32'h30000, 32'h40000, 32'h50000,
    32'h60000, 32'h70000, 32'hff0000, 32'h100001, 32'h120001, 32'h80003,
    32'hc0003, 32'h100000f, 32'h80000ff, 32'h90000ff, 32'ha0000ff, 32'hb0000ff,
    32'hc0000ff, 32'hd0000ff, 32'he0000ff, 32'hf0000ff, 32'hd0000fff, 32'he00007ff,
    32'hf0000fff, 32'h20001fff, 32'hec0001ff, 32'hef0000ff, 32'hee00003f};

  always #50 clk = ~clk;

  cltd_prog_mem cltd_prog_mem_inst (.clk(clk), .rst(rst), .go(go), .stall(stall),
    .instrReady(instrReady), .instrValid(instrValid), .instrWord(instrWord),
    .instrAddr(instrAddr));
  cltd_decoder cltd_decoder_inst (.clk(clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .instrAddr(instrAddr), .flagZero(flagZero), .flagCarry(flagCarry),
    .flagWrap(flagWrap), .flagNegative(flagNegative), .tblWriteStartsMem(tblWriteStartsMem),
    .memWriteDone(memWriteDone), .timerZeroWrite(timerZeroWrite),
    .prescalerOnTimerZero(prescalerOnTimerZero), .portRmwAccess(portRmwAccess),
    .instrReady(instrReady), .opValid(opValid), .opCode(opCode), .literal8(literal8),
    .literal12(literal12), .pointerSel(pointerSel), .tableMode(tableMode), .shadowSel(shadowSel),
    .statusUpdateMask(statusUpdateMask), .opCycles(opCycles), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .tblWriteActive(tblWriteActive), .prescalerClear(prescalerClear),
    .rmwFromPins(rmwFromPins));

  task automatic check(logic [63:0] got, logic [63:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic cltd_exp_t dec(logic [15:0] w, logic [20:0] a, logic lng);
    cltd_exp_t  r;
    logic [3:0] f;
    logic       tk;
    f = {flagNegative, flagWrap, flagCarry, flagZero};
    tk = f[w[10:9]] ^ w[8];
    r = '{OP_OUTSIDE_GROUP, 7'h00, 3'h1, 1'b0, 1'b0, a + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0},
          {3'h0, w[0], w[1:0], w[7:0]}, 2'h0};
    casez (w)
      16'h0000: r.op = OP_NO_OPERATION;
      16'h0003: {r.op, r.mask} = {OP_STANDBY, 7'h20};
      16'h0004: {r.op, r.mask} = {OP_WATCHDOG_CLEAR, 7'h20};
      16'h0005: r.op = OP_STACK_PUSH;
      16'h0006: r.op = OP_STACK_POP;
      16'h0007: {r.op, r.mask} = {OP_DECIMAL_ADJUST, 7'h01};
      16'h00ff: {r.op, r.mask} = {OP_SOFT_RESET, 7'h7f};
      16'h001?: {r.op, r.mask, r.cyc, r.pl} = {w[1] ? OP_SUB_RETURN : OP_INTERRUPT_RETURN,
                w[1] ? 7'h00 : 7'h40, 3'h2, 1'b1};
      16'h000?: {r.op, r.cyc} = {w[2] ? OP_TABLE_WRITE : OP_TABLE_READ,
                w[2] && lng ? 3'h5 : 3'h2};
      16'h010?: {r.op, r.lit} = {OP_BANK_LITERAL_LOAD, 3'h0, w[0], w[1:0], 4'h0, w[3:0]};
      16'h08??: {r.op, r.mask} = {OP_LITERAL_SUBTRACT, 7'h1f};
      16'h09??: {r.op, r.mask} = {OP_LITERAL_OR, 7'h14};
      16'h0a??: {r.op, r.mask} = {OP_LITERAL_XOR, 7'h14};
      16'h0b??: {r.op, r.mask} = {OP_LITERAL_AND, 7'h14};
      16'h0c??: {r.op, r.cyc, r.pl} = {OP_EXIT_WITH_LITERAL, 3'h2, 1'b1};
      16'h0d??: r.op = OP_LITERAL_MULTIPLY;
      16'h0e??: r.op = OP_LITERAL_LOAD;
      16'h0f??: {r.op, r.mask} = {OP_LITERAL_ADD, 7'h1f};
      16'hd???: {r.op, r.cyc, r.pl, r.ct, r.tgt} = {w[11] ? OP_RELATIVE_INVOKE : OP_JUMP_RELATIVE,
                5'h0b, a + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0}};
      16'b1110_0???_????_????: {r.op, r.cyc, r.pl, r.ct} = {OP_BRANCH_COND,
                tk ? 5'h0b : 5'h04};
      16'hf???: r.op = OP_NO_OPERATION;
      default: r.op = OP_OUTSIDE_GROUP;
    endcase
    return r;
  endfunction

  // sampled at the falling edge, when all has settled
  always @(negedge clk)
  begin
    if (rst)
    begin
      {pend, act, pP, pR} = 4'h0;
      q.delete();
    end
    else
    begin
      check(prescalerClear, pP);
      check(rmwFromPins, pR);
      check(tblWriteActive, act);
      if (opValid)
      begin
        e = q.pop_front();
        e.tgt &= {21{e.ct}};
        s = '{opCode, statusUpdateMask, opCycles, pcLoad, e.ct, e.ct ? pcTarget : 21'h0,
              e.lk == 2'h0 ? {3'h0, shadowSel, tableMode, literal8}
              : (e.lk == 2'h1 ? {pointerSel, literal12} : 14'h0), e.lk};
        check(s, e);
      end
      pP = timerZeroWrite && prescalerOnTimerZero;
      pR = portRmwAccess;
      if (memWriteDone)
        act = 1'b0;
      if (instrValid && instrReady && pend)
      begin
        pend = 1'b0;
        e = '{OP_ABSOLUTE_JUMP, 7'h00, 3'h2, 1'b1, 1'b1, {instrWord[11:0], pw[7:0], 1'b0},
              {3'h0, pw[0], pw[1:0], pw[7:0]}, 2'h0};
        if (!pw[9])
          {e.op, e.lit[10]} = {OP_SUB_CALL, pw[8]};
        if (pw[9:8] == 2'h2)
          e = '{OP_POINTER_LITERAL_LOAD, 7'h00, 3'h2, 1'b0, 1'b0, 21'h0,
                {pw[5:0], instrWord[7:0]}, 2'h1};
        q.push_back(e);
      end
      else if (instrValid && instrReady && (instrWord[15:9] == 7'h76
               || instrWord[15:8] == 8'hef || instrWord[15:6] == 10'h3b8))
      begin
        pend = 1'b1;
        pw = instrWord;
      end
      else if (instrValid && instrReady)
      begin
        q.push_back(dec(instrWord, instrAddr, tblWriteStartsMem));
        if (instrWord[15:2] == 14'h0003 && tblWriteStartsMem)
          act = 1'b1;
      end
    end
  end

  initial
  begin
    int k;
    int t;
    {rst, go, stall} = 3'h4;
    {flagZero, flagCarry, flagWrap, flagNegative, tblWriteStartsMem, memWriteDone} = 6'h00;
    {timerZeroWrite, prescalerOnTimerZero, portRmwAccess} = 3'h0;
    void'($urandom(1600));
    k = 0;
    // each template once, then random; the three two-word templates get an operand word
    for (int i = 0; i < 400; i++)
    begin
      t = i < 27 ? i : $urandom_range(26);
      cltd_prog_mem_inst.mem[k] = tpl[t][31:16] | (16'($urandom) & tpl[t][15:0]);
      k++;
      if (t > 23)
      begin
        cltd_prog_mem_inst.mem[k] = 16'hf000 | (16'($urandom) & (t == 26 ? 16'h00ff : 16'h0fff));
        k++;
      end
    end
    cltd_prog_mem_inst.mem[k] = 16'h0000;
    cltd_prog_mem_inst.n = k;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    go <= 1'b1;
    // random memory stalls in the second half
    for (int c = 0; c < 9000 && cltd_prog_mem_inst.idx < k; c++)
    begin
      @(posedge clk);
      stall <= cltd_prog_mem_inst.idx > k / 2 && $urandom_range(1) == 1;
      {flagZero, flagCarry, flagWrap, flagNegative, tblWriteStartsMem} <= 5'($urandom);
      memWriteDone <= $urandom_range(3) == 0;
      {timerZeroWrite, prescalerOnTimerZero, portRmwAccess} <= 3'($urandom);
    end
    repeat (8) @(posedge clk);
    check({q.size(), cltd_prog_mem_inst.idx}, {32'h0, k});
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
